// ==== design/peripheral_irq_flags_7_to_9.sv ====
// request flag registers 7, 8 and 9 with a small interrupt summary
// assumes every peripheral input runs on i_clk; no synchronisers needed
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "irq_flags_7_9_consts.svh"
module peripheral_irq_flags_7_to_9 #(
    parameter int SRC_W = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire irq_flags_7_9_pkg::addr_t i_addr,
    input wire irq_flags_7_9_pkg::byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output irq_flags_7_9_pkg::byte_t o_rdata,
    // one-cycle event pulses of the clearable sources
    input wire logic i_pwm_period_evt,
    input wire logic i_logic_cell_3_evt,
    input wire logic i_memory_scanner_evt,
    input wire logic i_capcomp_2_evt,
    input wire logic i_timer5_gate_evt,
    input wire logic i_timer5_overflow_evt,
    input wire logic i_logic_cell_4_evt,
    // source registers behind the summary flags
    input wire logic [SRC_W-1:0] i_pwm_group_irq_reg,
    input wire logic [SRC_W-1:0] i_twowire_error_reg,
    input wire logic [SRC_W-1:0] i_twowire_protocol_irq_reg,
    input wire logic [SRC_W-1:0] i_uart2_irq_reg,
    input wire logic [SRC_W-1:0] i_uart2_error_reg,
    input wire logic [SRC_W-1:0] i_uart3_irq_reg,
    input wire logic [SRC_W-1:0] i_uart3_error_reg,
    // buffer state levels
    input wire logic i_twowire_tx_req,
    input wire logic i_twowire_rx_req,
    input wire logic i_twowire_clear_buffers_bit,
    input wire logic i_uart2_tx_req,
    input wire logic i_uart2_rx_req,
    input wire logic i_uart3_tx_req,
    input wire logic i_uart3_rx_req,
    // flag bytes and interrupt
    output irq_flags_7_9_pkg::byte_t o_req7,
    output irq_flags_7_9_pkg::byte_t o_req8,
    output irq_flags_7_9_pkg::byte_t o_req9,
    output logic o_irq
);
    import irq_flags_7_9_pkg::*;

    byte_t req7_r;
    byte_t req8_r;
    byte_t req9_r;
    byte_t req7_nxt;
    byte_t req8_nxt;
    byte_t req9_nxt;
    irq_vec_t status_r;
    irq_vec_t mask_r;
    irq_vec_t rise;
    logic wr7;
    logic wr8;
    logic wr9;

    assign wr7 = i_wr && (i_addr == `ADDR_REQ7);
    assign wr8 = i_wr && (i_addr == `ADDR_REQ8);
    assign wr9 = i_wr && (i_addr == `ADDR_REQ9);

    // clearable flag: event sets, write stores, event beats a write of 0
    function automatic logic sw_flag(input logic cur, input logic evt,
                                     input logic wr, input logic wbit);
        logic v;
        v = wr ? wbit : cur;
        return v | evt;
    endfunction

    // next value of every flag
    always_comb begin
        req7_nxt = `REQ_RESET;
        req8_nxt = `REQ_RESET;
        req9_nxt = `REQ_RESET;
        req7_nxt[`BIT_PWM_SUM] = |i_pwm_group_irq_reg;
        req7_nxt[`BIT_PWM_PER] = sw_flag(req7_r[`BIT_PWM_PER], i_pwm_period_evt,
            wr7, i_wdata[`BIT_PWM_PER]);
        req7_nxt[`BIT_CLC3] = sw_flag(req7_r[`BIT_CLC3], i_logic_cell_3_evt,
            wr7, i_wdata[`BIT_CLC3]);
        req7_nxt[`BIT_TW_ERR] = |i_twowire_error_reg;
        req7_nxt[`BIT_TW_GEN] = |i_twowire_protocol_irq_reg;
        req7_nxt[`BIT_TW_TX] = i_twowire_tx_req && !i_twowire_clear_buffers_bit;
        req7_nxt[`BIT_TW_RX] = i_twowire_rx_req && !i_twowire_clear_buffers_bit;
        req8_nxt[`BIT_SCAN] = sw_flag(req8_r[`BIT_SCAN], i_memory_scanner_evt,
            wr8, i_wdata[`BIT_SCAN]);
        req8_nxt[`BIT_CCP2] = sw_flag(req8_r[`BIT_CCP2], i_capcomp_2_evt,
            wr8, i_wdata[`BIT_CCP2]);
        req8_nxt[`BIT_TMR5G] = sw_flag(req8_r[`BIT_TMR5G], i_timer5_gate_evt,
            wr8, i_wdata[`BIT_TMR5G]);
        req8_nxt[`BIT_TMR5] = sw_flag(req8_r[`BIT_TMR5], i_timer5_overflow_evt,
            wr8, i_wdata[`BIT_TMR5]);
        req8_nxt[`BIT_UART_GEN] = |i_uart2_irq_reg;
        req8_nxt[`BIT_UART_ERR] = |i_uart2_error_reg;
        req8_nxt[`BIT_UART_TX] = i_uart2_tx_req;
        req8_nxt[`BIT_UART_RX] = i_uart2_rx_req;
        req9_nxt[`BIT_CLC4] = sw_flag(req9_r[`BIT_CLC4], i_logic_cell_4_evt,
            wr9, i_wdata[`BIT_CLC4]);
        req9_nxt[`BIT_UART_GEN] = |i_uart3_irq_reg;
        req9_nxt[`BIT_UART_ERR] = |i_uart3_error_reg;
        req9_nxt[`BIT_UART_TX] = i_uart3_tx_req;
        req9_nxt[`BIT_UART_RX] = i_uart3_rx_req;
    end

    // flag registers; summary bits take no bus write
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            req7_r <= `REQ_RESET;
            req8_r <= `REQ_RESET;
            req9_r <= `REQ_RESET;
        end else begin
            req7_r <= req7_nxt & `REQ7_IMPL;
            req8_r <= req8_nxt;
            req9_r <= req9_nxt & `REQ9_IMPL;
        end
    end

    // a register reports an event when any of its flags rises
    assign rise[0] = |(req7_nxt & `REQ7_IMPL & ~req7_r);
    assign rise[1] = |(req8_nxt & ~req8_r);
    assign rise[2] = |(req9_nxt & `REQ9_IMPL & ~req9_r);

    // sticky status, cleared by its read; a new rise wins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            status_r <= `IRQ_RESET;
        end else if (i_rd && (i_addr == `ADDR_IRQ_STATUS)) begin
            status_r <= rise;
        end else begin
            status_r <= status_r | rise;
        end
    end

    // interrupt mask
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_r <= `IRQ_RESET;
        end else if (i_wr && (i_addr == `ADDR_IRQ_MASK)) begin
            mask_r <= i_wdata[2:0];
        end
    end

    // interrupt output follows the status and mask just stored
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else if (i_rd && (i_addr == `ADDR_IRQ_STATUS)) begin
            o_irq <= |(rise & mask_r);
        end else begin
            o_irq <= |((status_r | rise) & ((i_wr && (i_addr == `ADDR_IRQ_MASK)) ?
                i_wdata[2:0] : mask_r));
        end
    end

    // read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                `ADDR_REQ7: o_rdata <= req7_r;
                `ADDR_REQ8: o_rdata <= req8_r;
                `ADDR_REQ9: o_rdata <= req9_r;
                `ADDR_IRQ_STATUS: o_rdata <= {5'h00, status_r};
                `ADDR_IRQ_MASK: o_rdata <= {5'h00, mask_r};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // flag bytes toward the vector logic
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_req7 <= `REQ_RESET;
            o_req8 <= `REQ_RESET;
            o_req9 <= `REQ_RESET;
        end else begin
            o_req7 <= req7_nxt & `REQ7_IMPL;
            o_req8 <= req8_nxt;
            o_req9 <= req9_nxt & `REQ9_IMPL;
        end
    end
endmodule

// ==== design/irq_flags_7_9_consts.svh ====
// constants of the peripheral request flag registers 7 to 9
// assumes a 12-bit byte address on a plain register port
// Behaviour
// - hardware sets each flag on its event, whatever the enables say
// - clearable flags read 1 after event, stay until software writes 0
// - summary flags read 1 while source pends, ignore bus writes
// - register 0x4B5: pwm summary, pwm period, logic cell 3, two-wire bits
// - register 0x4B6: scanner, capcomp 2, timer 5 gate/overflow, uart2 bits
// - register 0x4B7: logic cell 4 in bit 5, uart3 in bits 3..0
// - pwm summary flag clears only when whole pwm group register is clear
// - two-wire error flag clears only when its error register is clear
// - two-wire general flag clears only when protocol register is clear
// - clear-buffers bit drops two-wire transmit and receive flags
// - uart2 general flag clears only when uart2 interrupt register clear
// - uart2 framing flag clears only when uart2 error register clear
// - uart2 transmit/receive flags follow buffer state, never written
// - uart3 flags behave as uart2 flags, read-only
`ifndef IRQ_FLAGS_7_9_CONSTS_SVH
`define IRQ_FLAGS_7_9_CONSTS_SVH
`define ADDR_REQ7 12'h4b5
`define ADDR_REQ8 12'h4b6
`define ADDR_REQ9 12'h4b7
`define ADDR_IRQ_STATUS 12'h4f0
`define ADDR_IRQ_MASK 12'h4f1
`define REQ_RESET 8'h00
`define IRQ_RESET 3'h0
`define REQ7_IMPL 8'hef
`define REQ9_IMPL 8'h2f
`define BIT_PWM_SUM 7
`define BIT_PWM_PER 6
`define BIT_CLC3 5
`define BIT_TW_ERR 3
`define BIT_TW_GEN 2
`define BIT_TW_TX 1
`define BIT_TW_RX 0
`define BIT_SCAN 7
`define BIT_CCP2 6
`define BIT_TMR5G 5
`define BIT_TMR5 4
`define BIT_UART_GEN 3
`define BIT_UART_ERR 2
`define BIT_UART_TX 1
`define BIT_UART_RX 0
`define BIT_CLC4 5
`endif

// ==== design/irq_flags_7_9_pkg.sv ====
// types shared by the request flag block
// assumes the constants header is included where offsets are needed
package irq_flags_7_9_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [11:0] addr_t;
    typedef logic [2:0] irq_vec_t;
endpackage

// ==== bench/irq_flags_7_9_asserts.sv ====
// port checks of the request flag block
// assumes the constants header is on the include path
`timescale 1ns/1ps
`include "irq_flags_7_9_consts.svh"
module irq_flags_7_9_asserts #(
    parameter int SRC_W = 8
) (
    // clock, reset and bus
    input wire logic i_clk,
    input wire logic i_rst,
    input wire irq_flags_7_9_pkg::addr_t i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire irq_flags_7_9_pkg::byte_t o_rdata,
    // flags and their sources
    input wire irq_flags_7_9_pkg::byte_t o_req7,
    input wire irq_flags_7_9_pkg::byte_t o_req8,
    input wire irq_flags_7_9_pkg::byte_t o_req9,
    input wire logic i_capcomp_2_evt,
    input wire logic i_twowire_clear_buffers_bit,
    input wire logic [SRC_W-1:0] i_pwm_group_irq_reg,
    input wire logic [SRC_W-1:0] i_uart2_irq_reg
);
    import irq_flags_7_9_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_unimpl;
        (o_req7 & ~`REQ7_IMPL) == 8'h00 && (o_req9 & ~`REQ9_IMPL) == 8'h00;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
    property p_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_rd7; i_rd && i_addr == `ADDR_REQ7 |=> o_rdata == $past(o_req7); endproperty
    a_rd7: assert property (p_rd7) else $error("register 7 read mismatch");
    property p_evt; i_capcomp_2_evt |=> o_req8[6]; endproperty
    a_evt: assert property (p_evt) else $error("event flag not set");
    property p_pwm; o_req7[7] == ($past(i_pwm_group_irq_reg) != 0); endproperty
    a_pwm: assert property (p_pwm) else $error("pwm summary wrong");
    property p_u2; o_req8[3] == ($past(i_uart2_irq_reg) != 0); endproperty
    a_u2: assert property (p_u2) else $error("uart2 summary wrong");
    property p_clr; i_twowire_clear_buffers_bit |=> o_req7[1:0] == 2'b00; endproperty
    a_clr: assert property (p_clr) else $error("buffer flags not dropped");
    property p_stick; o_req8[6] && !(i_wr && i_addr == `ADDR_REQ8) |=> o_req8[6]; endproperty
    a_stick: assert property (p_stick) else $error("flag lost without write");
endmodule
bind peripheral_irq_flags_7_to_9 irq_flags_7_9_asserts #(.SRC_W(SRC_W)) chk_u (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_addr(i_addr),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_req7(o_req7),
    .o_req8(o_req8),
    .o_req9(o_req9),
    .i_capcomp_2_evt(i_capcomp_2_evt),
    .i_twowire_clear_buffers_bit(i_twowire_clear_buffers_bit),
    .i_pwm_group_irq_reg(i_pwm_group_irq_reg),
    .i_uart2_irq_reg(i_uart2_irq_reg)
);

// ==== bench/peripheral_irq_flags_7_to_9_bench.sv ====
// bench of the request flag registers 7 to 9
// assumes design and checker compiled first
`timescale 1ns/1ps
`include "irq_flags_7_9_consts.svh"
module peripheral_irq_flags_7_to_9_bench;
    import irq_flags_7_9_pkg::*;
    logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, clr = 0, o_irq;
    addr_t i_addr = '0;
    byte_t i_wdata = '0, o_rdata, o_req7, o_req8, o_req9;
    logic [6:0] evt = '0;
    logic [5:0] lv = '0;
    logic [7:0] src [7] = '{default: 8'h00};
    int err_count = 0, checks = 0;
    always #50 i_clk = ~i_clk;
    peripheral_irq_flags_7_to_9 uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_pwm_period_evt(evt[0]), .i_logic_cell_3_evt(evt[1]), .i_memory_scanner_evt(evt[2]),
        .i_capcomp_2_evt(evt[3]), .i_timer5_gate_evt(evt[4]), .i_timer5_overflow_evt(evt[5]),
        .i_logic_cell_4_evt(evt[6]), .i_pwm_group_irq_reg(src[0]), .i_twowire_error_reg(src[1]),
        .i_twowire_protocol_irq_reg(src[2]), .i_uart2_irq_reg(src[3]), .i_uart2_error_reg(src[4]),
        .i_uart3_irq_reg(src[5]), .i_uart3_error_reg(src[6]), .i_twowire_tx_req(lv[0]),
        .i_twowire_rx_req(lv[1]), .i_twowire_clear_buffers_bit(clr), .i_uart2_tx_req(lv[2]),
        .i_uart2_rx_req(lv[3]), .i_uart3_tx_req(lv[4]), .i_uart3_rx_req(lv[5]), .o_req7(o_req7),
        .o_req8(o_req8), .o_req9(o_req9), .o_irq(o_irq));
    task chk(input byte_t got, input byte_t exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task wr(input addr_t a, input byte_t d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input addr_t a, input byte_t e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    task pulse(input logic [6:0] v);
        @(posedge i_clk);
        evt <= v;
        @(posedge i_clk);
        evt <= 7'h00;
    endtask
    task t_events;
        rd(`ADDR_REQ7, 8'h00);
        rd(12'h4b4, 8'h00);
        pulse(7'h7f);
        rd(`ADDR_REQ7, 8'h60);
        rd(`ADDR_REQ8, 8'hf0);
        rd(`ADDR_REQ9, 8'h20);
        wr(`ADDR_REQ8, 8'h00);
        rd(`ADDR_REQ8, 8'h00);
        wr(`ADDR_REQ9, 8'hff);
        rd(`ADDR_REQ9, 8'h20);
        $display("events done");
    endtask
    task t_summary;
        wr(`ADDR_REQ7, 8'h00);
        wr(`ADDR_REQ9, 8'h00);
        for (int k = 0; k < 7; k++) src[k] <= 8'h80;
        lv <= 6'h3f;
        wr(`ADDR_REQ8, 8'h00);
        rd(`ADDR_REQ7, 8'h8f);
        rd(`ADDR_REQ8, 8'h0f);
        rd(`ADDR_REQ9, 8'h0f);
        wr(`ADDR_REQ7, 8'hff);
        rd(`ADDR_REQ7, 8'hef);
        clr <= 1'b1;
        wr(`ADDR_REQ7, 8'h00);
        rd(`ADDR_REQ7, 8'h8c);
        for (int k = 0; k < 7; k++) src[k] <= 8'h00;
        lv <= 6'h00;
        clr <= 1'b0;
        rd(`ADDR_REQ7, 8'h00);
        rd(`ADDR_REQ8, 8'h00);
        $display("summary done");
    endtask
    task t_irq;
        rd(`ADDR_IRQ_STATUS, 8'h07);
        rd(`ADDR_IRQ_MASK, 8'h00);
        wr(`ADDR_IRQ_MASK, 8'h02);
        pulse(7'h08);
        #1;
        for (int n = 0; n < 4 && o_irq !== 1'b1; n++) #100;
        chk({7'h00, o_irq}, 8'h01);
        if (o_irq !== 1'b1) results();
        rd(`ADDR_IRQ_STATUS, 8'h02);
        pulse(7'h40);
        repeat (3) @(posedge i_clk);
        #1 chk({7'h00, o_irq}, 8'h00);
        rd(`ADDR_IRQ_STATUS, 8'h04);
        $display("interrupt done");
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        t_events();
        t_summary();
        t_irq();
        results();
    end
    initial begin
        #100000;
        err_count++;
        results();
    end
endmodule
